// >>> lqm_pkg.sv
// package for the link quality monitor: register map, fields, types
package lqm_pkg;
  // register offsets 1Dh/1Eh are not multiples of four: kept as indices
  localparam int unsigned LQM_IDX_MON   = 32'h0000_001D;
  localparam int unsigned LQM_IDX_THR   = 32'h0000_001E;
  localparam int unsigned LQM_IDX_IMASK = 32'h0000_0020;
  localparam int unsigned LQM_IDX_ISTAT = 32'h0000_0021;
  localparam int unsigned LQM_IDX_AUTO  = 32'h0000_0022;
  localparam logic [11:0] LQM_ADDR_MON   = 12'(LQM_IDX_MON * 4);
  localparam logic [11:0] LQM_ADDR_THR   = 12'(LQM_IDX_THR * 4);
  localparam logic [11:0] LQM_ADDR_IMASK = 12'(LQM_IDX_IMASK * 4);
  localparam logic [11:0] LQM_ADDR_ISTAT = 12'(LQM_IDX_ISTAT * 4);
  localparam logic [11:0] LQM_ADDR_AUTO  = 12'(LQM_IDX_AUTO * 4);

  localparam int LQM_NPARAM       = 5;
  localparam int LQM_BIT_ENABLE   = 15;
  localparam int LQM_BIT_SAMPLE   = 13;
  localparam int LQM_BIT_WTRIG    = 12;
  localparam int LQM_SEL_HI       = 11;
  localparam int LQM_SEL_LO       = 9;
  localparam int LQM_BIT_SIDE     = 8;
  localparam int LQM_DATA_HI      = 7;
  localparam int LQM_WARN_HI      = 9;
  localparam logic [7:0] LQM_THR_MAX = 8'hFF;
  localparam logic [7:0] LQM_THR_MIN = 8'h00;
  localparam logic [7:0] LQM_THR_RST_HI = 8'hFF;
  localparam logic [7:0] LQM_THR_RST_LO = 8'h00;

  typedef enum logic [2:0] {
    LQM_P_COEFF  = 3'h0,
    LQM_P_GAIN   = 3'h1,
    LQM_P_WANDER = 3'h2,
    LQM_P_OFFSET = 3'h3,
    LQM_P_FCTRL  = 3'h4
  } lqm_param_t;

  typedef struct packed {
    logic [7:0] coeff;
    logic [7:0] gain;
    logic [7:0] wander;
    logic [7:0] offset;
    logic [7:0] fctrl;
  } lqm_params_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } lqm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lqm_apb_rsp_t;

  typedef enum logic [1:0] {LQM_ST_IDLE, LQM_ST_RESET} lqm_state_t;
endpackage : lqm_pkg

// >>> lqm_monitor.sv
// link quality monitor: thresholds, sticky warnings, interrupt, auto link reset
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module lqm_monitor #(
  parameter int RESET_PULSE = 4
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire lqm_pkg::lqm_apb_req_t apb_req,
  output lqm_pkg::lqm_apb_rsp_t      apb_rsp,
  input  wire logic                  link_100_up,
  input  wire lqm_pkg::lqm_params_t  params,
  output logic                       irq,
  output logic                       link_reset
);
  import lqm_pkg::*;

  // the pulse counter is eight bits wide, so longer pulses cannot be served
  if (RESET_PULSE < 1 || RESET_PULSE > 255)
  begin : g_bad_pulse
    $error("RESET_PULSE out of range");
  end

  logic [7:0]  thr_hi_q [LQM_NPARAM];
  logic [7:0]  thr_lo_q [LQM_NPARAM];
  logic        enable_q;
  logic [9:0]  warn_q;
  logic [9:0]  warn_d;
  logic [2:0]  sel_q;
  logic        side_q;
  logic        sample_q;
  logic [7:0]  sampled_q;
  logic        imask_q;
  logic        istat_q;
  logic        armed_q;
  logic        auto_en_q;
  logic [7:0]  rst_cnt_q;
  lqm_state_t  state_q;
  logic [31:0] prdata_q;

  function automatic logic [7:0] pick(input lqm_params_t p, input logic [2:0] s);
    case (s)
      LQM_P_COEFF:  pick = p.coeff;
      LQM_P_GAIN:   pick = p.gain;
      LQM_P_WANDER: pick = p.wander;
      LQM_P_OFFSET: pick = p.offset;
      LQM_P_FCTRL:  pick = p.fctrl;
      default:      pick = 8'h00;
    endcase
  endfunction : pick

  wire logic       wr_en   = apb_req.psel & apb_req.penable & apb_req.pwrite;
  wire logic       rd_en   = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
  wire logic       hit_mon = apb_req.paddr == LQM_ADDR_MON;
  wire logic       hit_thr = apb_req.paddr == LQM_ADDR_THR;
  wire logic       hit_msk = apb_req.paddr == LQM_ADDR_IMASK;
  wire logic       hit_ist = apb_req.paddr == LQM_ADDR_ISTAT;
  wire logic       hit_aut = apb_req.paddr == LQM_ADDR_AUTO;
  wire logic       mapped  = hit_mon | hit_thr | hit_msk | hit_ist | hit_aut;
  wire logic       mon_rd  = rd_en & hit_mon;
  wire logic       running = enable_q & link_100_up;
  wire logic [2:0] wsel    = apb_req.pwdata[LQM_SEL_HI:LQM_SEL_LO];
  wire logic       wside   = apb_req.pwdata[LQM_BIT_SIDE];
  wire logic       thr_wr  = wr_en & hit_thr & apb_req.pwdata[LQM_BIT_WTRIG]
                             & (wsel < 3'(LQM_NPARAM));

  // a threshold at its extreme can never be crossed, which disables that check
  logic [9:0] viol;
  always_comb
  begin
    viol = '0;
    for (int i = 0; i < LQM_NPARAM; i++)
    begin
      viol[2*i+1] = running && thr_hi_q[i] != LQM_THR_MAX
                    && pick(params, 3'(i)) > thr_hi_q[i];
      viol[2*i]   = running && thr_lo_q[i] != LQM_THR_MIN
                    && pick(params, 3'(i)) < thr_lo_q[i];
    end
  end

  // set wins over the clear-on-read in the same cycle
  assign warn_d = (mon_rd ? 10'h000 : warn_q) | viol;

  wire logic [31:0] mon_word = {16'h0000, enable_q, 5'h00, warn_q};
  wire logic [31:0] thr_word = {18'h00000, sample_q, 1'b0, sel_q, side_q,
                                sample_q ? sampled_q
                                         : (side_q ? thr_hi_q[sel_q] : thr_lo_q[sel_q])};
  wire logic [31:0] rd_word  = hit_mon ? mon_word
                             : hit_thr ? thr_word
                             : hit_msk ? {31'h0, imask_q}
                             : hit_ist ? {31'h0, istat_q}
                             : hit_aut ? {31'h0, auto_en_q}
                             : 32'h0000_0000;

  wire logic slverr = apb_req.psel & apb_req.penable & ~mapped;
  assign apb_rsp = {prdata_q, 1'b1, slverr};

  // interrupt fires once per armed period; a monitor read re-arms it
  wire logic new_viol = |viol & armed_q;
  assign irq = istat_q & imask_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < LQM_NPARAM; i++)
      begin
        thr_hi_q[i] <= LQM_THR_RST_HI;
        thr_lo_q[i] <= LQM_THR_RST_LO;
      end
    end
    else if (thr_wr)
    begin
      if (wside)
        thr_hi_q[wsel] <= apb_req.pwdata[LQM_DATA_HI:0];
      else
        thr_lo_q[wsel] <= apb_req.pwdata[LQM_DATA_HI:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_q <= 1'b0;
      warn_q   <= '0;
      prdata_q <= '0;
    end
    else
    begin
      warn_q <= warn_d;
      if (wr_en && hit_mon)
        enable_q <= apb_req.pwdata[LQM_BIT_ENABLE];
      if (rd_en)
        prdata_q <= rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q     <= '0;
      side_q    <= 1'b0;
      sample_q  <= 1'b0;
      sampled_q <= '0;
    end
    else if (wr_en && hit_thr)
    begin
      sel_q    <= wsel;
      side_q   <= wside;
      sample_q <= apb_req.pwdata[LQM_BIT_SAMPLE];
      if (apb_req.pwdata[LQM_BIT_SAMPLE])
        sampled_q <= pick(params, wsel);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      imask_q   <= 1'b0;
      istat_q   <= 1'b0;
      armed_q   <= 1'b1;
      auto_en_q <= 1'b0;
    end
    else
    begin
      if (wr_en && hit_msk)
        imask_q <= apb_req.pwdata[0];
      if (wr_en && hit_aut)
        auto_en_q <= apb_req.pwdata[0];
      if (new_viol)
        istat_q <= 1'b1;
      else if (wr_en && hit_ist && apb_req.pwdata[0])
        istat_q <= 1'b0;
      if (new_viol)
        armed_q <= 1'b0;
      else if (mon_rd)
        armed_q <= 1'b1;
    end
  end

  // auto reset pulses the link once per new violation episode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q   <= LQM_ST_IDLE;
      rst_cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        LQM_ST_IDLE:
        begin
          if (new_viol && auto_en_q)
          begin
            state_q   <= LQM_ST_RESET;
            rst_cnt_q <= 8'(RESET_PULSE - 1);
          end
        end
        LQM_ST_RESET:
        begin
          if (rst_cnt_q == 8'h00)
            state_q <= LQM_ST_IDLE;
          else
            rst_cnt_q <= rst_cnt_q - 8'h01;
        end
        default: state_q <= LQM_ST_IDLE;
      endcase
    end
  end

  assign link_reset = state_q == LQM_ST_RESET;

  property p_no_check_idle;
    @(posedge pclk) disable iff (!presetn)
      !(enable_q && link_100_up) |-> viol == 10'h000;
  endproperty
  a_no_check_idle: assert property (p_no_check_idle) else $error("check while idle");

  property p_max_disables;
    @(posedge pclk) disable iff (!presetn)
      thr_hi_q[0] == LQM_THR_MAX |-> !viol[1];
  endproperty
  a_max_disables: assert property (p_max_disables) else $error("max threshold fired");

  property p_irq_set;
    @(posedge pclk) disable iff (!presetn)
      (new_viol && imask_q) ##1 imask_q |-> irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt not raised");

  property p_read_clears;
    @(posedge pclk) disable iff (!presetn)
      mon_rd && viol == 10'h000 |=> warn_q == 10'h000 && armed_q;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear");

  property p_fc_hi;
    @(posedge pclk) disable iff (!presetn)
      viol[LQM_WARN_HI] |=> warn_q[LQM_WARN_HI];
  endproperty
  a_fc_hi: assert property (p_fc_hi) else $error("fctrl high lost");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
      warn_q[6] && !mon_rd |=> warn_q[6];
  endproperty
  a_sticky: assert property (p_sticky) else $error("offset low dropped");

  property p_wander_lo;
    @(posedge pclk) disable iff (!presetn)
      running && params.wander < thr_lo_q[2] && thr_lo_q[2] != LQM_THR_MIN |=> warn_q[4];
  endproperty
  a_wander_lo: assert property (p_wander_lo) else $error("wander low missed");

  property p_gain_hi;
    @(posedge pclk) disable iff (!presetn)
      $rose(warn_q[3]) |-> $past(viol[3]);
  endproperty
  a_gain_hi: assert property (p_gain_hi) else $error("gain high spurious");

  property p_coeff_lo;
    @(posedge pclk) disable iff (!presetn)
      $rose(warn_q[0]) |-> $past(running);
  endproperty
  a_coeff_lo: assert property (p_coeff_lo) else $error("coeff low spurious");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
      mon_word[14:10] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_auto_reset;
    @(posedge pclk) disable iff (!presetn)
      state_q == LQM_ST_IDLE && new_viol && auto_en_q |=> link_reset ##[0:255] !link_reset;
  endproperty
  a_auto_reset: assert property (p_auto_reset) else $error("auto reset wrong");

  property p_trig_zero;
    @(posedge pclk) disable iff (!presetn)
      thr_word[LQM_BIT_WTRIG] == 1'b0;
  endproperty
  a_trig_zero: assert property (p_trig_zero) else $error("trigger reads one");

  property p_thr_load;
    @(posedge pclk) disable iff (!presetn)
      thr_wr && wside && wsel == 3'h4 |=> thr_hi_q[4] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_thr_load: assert property (p_thr_load) else $error("threshold not loaded");

  property p_fc_lo;
    @(posedge pclk) disable iff (!presetn)
      viol[8] |=> warn_q[8];
  endproperty
  a_fc_lo: assert property (p_fc_lo) else $error("fctrl low lost");

  property p_wander_hi;
    @(posedge pclk) disable iff (!presetn)
      viol[5] |=> warn_q[5];
  endproperty
  a_wander_hi: assert property (p_wander_hi) else $error("wander high lost");

  property p_gain_lo;
    @(posedge pclk) disable iff (!presetn)
      viol[2] |=> warn_q[2];
  endproperty
  a_gain_lo: assert property (p_gain_lo) else $error("gain low lost");

  property p_rearm;
    @(posedge pclk) disable iff (!presetn)
      mon_rd && !new_viol |=> armed_q;
  endproperty
  a_rearm: assert property (p_rearm) else $error("read did not re-arm");

  property p_istat_set;
    @(posedge pclk) disable iff (!presetn)
      new_viol |=> istat_q;
  endproperty
  a_istat_set: assert property (p_istat_set) else $error("status not set");

  property p_pulse_len;
    @(posedge pclk) disable iff (!presetn)
      $rose(link_reset) |-> rst_cnt_q == 8'(RESET_PULSE - 1);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
endmodule : lqm_monitor

// >>> lqm_rx_model.sv
// receiver model: drives the adapted parameters and the link state
`timescale 1ns/1ps
module lqm_rx_model (
  input  wire logic          pclk,
  output lqm_pkg::lqm_params_t params,
  output logic               link_100_up
);
  import lqm_pkg::*;
  initial
  begin
    params      = '0;
    link_100_up = 1'b0;
  end
  // values move just after an edge, as the adaptation loop would
  task automatic put(input lqm_params_t p, input logic up);
    @(posedge pclk);
    params      <= p;
    link_100_up <= up;
  endtask : put
endmodule : lqm_rx_model

// >>> testbench.sv
// self-checking bench for the link quality monitor
`timescale 1ns/1ps
module testbench;
  import lqm_pkg::*;
  logic         pclk;
  logic         presetn;
  lqm_apb_req_t apb_req;
  lqm_apb_rsp_t apb_rsp;
  lqm_params_t  params;
  logic         link_100_up;
  logic         irq;
  logic         link_reset;
  int           err_total;
  int           comparisons;
  int           pulse_cnt;
  logic [31:0]  exp_q[$];
  logic         rd_seen;
  logic         exp_err;
  integer       seed;

  lqm_monitor #(.RESET_PULSE(2)) dut (
    .pclk        (pclk),
    .presetn     (presetn),
    .apb_req     (apb_req),
    .apb_rsp     (apb_rsp),
    .link_100_up (link_100_up),
    .params      (params),
    .irq         (irq),
    .link_reset  (link_reset)
  );

  lqm_rx_model rx (
    .pclk        (pclk),
    .params      (params),
    .link_100_up (link_100_up)
  );

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // one idle edge before each setup keeps the strobes from being driven twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.paddr   <= a;
    apb_req.pwrite  <= w;
    apb_req.pwdata  <= d;
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (apb_rsp.pready !== 1'b1);
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // in-band values sit strictly between the programmed thresholds
  function automatic lqm_params_t calm();
    logic [39:0] v;
    for (int k = 0; k < 5; k++)
      v[8*k+:8] = 8'h71 + 8'($unsigned($random(seed)) % 31);
    return lqm_params_t'(v);
  endfunction : calm

  task automatic viol(input int i, input logic [7:0] v, input logic up);
    logic [39:0] p;
    p = calm();
    p[8*(4-i)+:8] = v;
    rx.put(lqm_params_t'(p), up);
    repeat (3) @(posedge pclk);
    rx.put(calm(), 1'b1);
    repeat (2) @(posedge pclk);
  endtask : viol

  // read data is registered at the access edge, so it is taken one edge later
  always @(posedge pclk)
  begin
    if (rd_seen && exp_q.size() > 0)
      check(apb_rsp.prdata, exp_q.pop_front());
    if (apb_req.psel && apb_req.penable)
      check({31'h0, apb_rsp.pslverr}, {31'h0, exp_err});
    if (link_reset === 1'b1)
      pulse_cnt++;
    rd_seen <= apb_req.psel & apb_req.penable & apb_rsp.pready & ~apb_req.pwrite;
  end

  initial
  begin
    #(25 * 10000);
    err_total++;
    report_and_stop();
  end

  initial
  begin
    apb_req     = '0;
    presetn     = 1'b0;
    err_total   = 0;
    comparisons = 0;
    pulse_cnt   = 0;
    rd_seen     = 1'b0;
    exp_err     = 1'b0;
    seed        = 32'h6AF4FD0D;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rx.put(calm(), 1'b1);
    for (int s = 0; s < 10; s++)
    begin
      apb(1'b1, LQM_ADDR_THR, {20'h0, 3'(s / 2), 1'(s % 2), 8'h00});
      rd(LQM_ADDR_THR, {20'h0, 3'(s / 2), 1'(s % 2), (s % 2) ? 8'hFF : 8'h00});
      apb(1'b1, LQM_ADDR_THR, {19'h0, 1'b1, 3'(s / 2), 1'(s % 2), (s % 2) ? 8'h90 : 8'h70});
      rd(LQM_ADDR_THR, {20'h0, 3'(s / 2), 1'(s % 2), (s % 2) ? 8'h90 : 8'h70});
    end
    // monitor still disabled, so these out-of-band values raise nothing
    rx.put(lqm_params_t'(40'h11_22_33_44_55), 1'b1);
    apb(1'b1, LQM_ADDR_THR, {18'h0, 1'b1, 1'b0, 3'h2, 1'b0, 8'h00});
    rd(LQM_ADDR_THR, {18'h0, 1'b1, 1'b0, 3'h2, 1'b0, 8'h33});
    viol(0, 8'hA0, 1'b1);
    rd(LQM_ADDR_MON, 32'h0);
    apb(1'b1, LQM_ADDR_MON, 32'hFFFF_FFFF);
    apb(1'b1, LQM_ADDR_IMASK, 32'h1);
    apb(1'b1, LQM_ADDR_AUTO, 32'h1);
    rd(LQM_ADDR_MON, 32'h8000);
    for (int s = 0; s < 10; s++)
    begin
      viol(s / 2, (s % 2) ? 8'hA0 : 8'h60, 1'b1);
      check({31'h0, irq}, 32'h1);
      rd(LQM_ADDR_MON, 32'h8000 | (32'h1 << s));
      rd(LQM_ADDR_MON, 32'h8000);
      apb(1'b1, LQM_ADDR_ISTAT, 32'h1);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
    end
    apb(1'b1, LQM_ADDR_IMASK, 32'h0);
    viol(1, 8'hA0, 1'b1);
    check({31'h0, irq}, 32'h0);
    rd(LQM_ADDR_ISTAT, 32'h1);
    rd(LQM_ADDR_MON, 32'h8008);
    viol(2, 8'hA0, 1'b0);
    rd(LQM_ADDR_MON, 32'h8000);
    apb(1'b1, LQM_ADDR_THR, {19'h0, 1'b1, 3'h0, 1'b1, 8'hFF});
    viol(0, 8'hFF, 1'b1);
    rd(LQM_ADDR_MON, 32'h8000);
    exp_err <= 1'b1;
    rd(12'hFFC, 32'h0);
    exp_err <= 1'b0;
    repeat (4) @(posedge pclk);
    check(pulse_cnt, 32'd22);
    report_and_stop();
  end
endmodule : testbench
